// ### acl_audio_clk.sv
// Bit and frame clock master/slave control for three audio interfaces
// What this block does
// - Master: drive bit and frame clocks out
// - Bit and frame masters chosen independently
// - Clocks timed to system or async clock
// - Register access works with clocks stopped
// - SPI access allowed at all times
`timescale 1ns/10ps
`include "acl_map.svh"
module acl_audio_clk #(
    parameter int NUM_IF = `ACL_NUM_IF
) (
    // System clock domain
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    // System and async clock domain strobes, one per system clock cycle
    input  wire logic                     sys_tick,
    input  wire logic                     async_tick,
    // Per-interface configuration
    input  wire acl_pkg::acl_cfg_s        cfg [NUM_IF],
    // Interface clock pins
    input  wire acl_pkg::acl_clk_s        pin_in [NUM_IF],
    output acl_pkg::acl_clk_s             pin_out [NUM_IF],
    output acl_pkg::acl_clk_s             pin_oe [NUM_IF],
    // Resolved clocks and edges seen by the audio logic
    output acl_pkg::acl_clk_s             clk_level [NUM_IF],
    output acl_pkg::acl_evt_s             clk_evt [NUM_IF],
    // Control access status
    input  wire logic [19:0]              spi_addr,
    output logic                          spi_to_fw,
    output logic                          ctrl_ready
);
    import acl_pkg::*;

    // Register access needs no audio clock, so the control path is always open
    assign ctrl_ready = 1'b1;
    // Address region decode for the host's rate budget
    assign spi_to_fw = (spi_addr >= `ACL_FW_BASE);

    genvar g;
    generate
        for (g = 0; g < NUM_IF; g++) begin : gen_if
            logic [7:0] div_reg;
            logic [7:0] div_next;
            logic [8:0] bit_cnt_reg;
            logic [8:0] bit_cnt_next;
            logic       bclk_reg;
            logic       frame_reg;
            logic       tick;
            logic       gen_rise;
            logic       gen_fall;
            logic       in_bclk;
            logic       in_brise;
            logic       in_bfall;
            logic       in_frame;
            logic       in_frise;
            logic       in_ffall;
            logic       mst_frame_next;
            logic       bclk_d_reg;
            logic       frame_d_reg;
            logic       cur_bclk;
            logic       cur_frame;

            // Pick the clock domain strobe that serves this interface
            assign tick = cfg[g].use_async ? async_tick : sys_tick;

            acl_edge_sync u_bclk_sync (
                .clk   (clk_sys),
                .rst   (sys_rst),
                .pin   (pin_in[g].bclk),
                .level (in_bclk),
                .rise  (in_brise),
                .fall  (in_bfall)
            );

            acl_edge_sync u_frame_sync (
                .clk   (clk_sys),
                .rst   (sys_rst),
                .pin   (pin_in[g].frame),
                .level (in_frame),
                .rise  (in_frise),
                .fall  (in_ffall)
            );

            // Bit clock divider
            assign div_next = (div_reg == 8'h00) ? cfg[g].bclk_half : 8'(div_reg - 8'h01);
            assign gen_rise = tick && (div_reg == 8'h00) && !bclk_reg;
            assign gen_fall = tick && (div_reg == 8'h00) && bclk_reg;

            // Frame counter runs on the bit clock actually in use, own or external
            assign cur_bclk  = cfg[g].bclk_master ? bclk_reg : in_bclk;
            assign cur_frame = cfg[g].frame_master ? frame_reg : in_frame;
            assign bit_cnt_next = (bit_cnt_reg >= {cfg[g].frame_bits, 1'b0} - 9'h001) ?
                                  9'h000 : 9'(bit_cnt_reg + 9'h001);
            assign mst_frame_next = (bit_cnt_next < {1'b0, cfg[g].frame_bits});

            logic cur_bfall;
            assign cur_bfall = cfg[g].bclk_master ? gen_fall : in_bfall;

            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    div_reg     <= `ACL_DIV_RST;
                    bclk_reg    <= 1'b0;
                    frame_reg   <= 1'b0;
                    bit_cnt_reg <= 9'h000;
                    bclk_d_reg  <= 1'b0;
                    frame_d_reg <= 1'b0;
                end else begin
                    if (tick)
                        div_reg <= div_next;
                    if (gen_rise || gen_fall)
                        bclk_reg <= ~bclk_reg;
                    if (cur_bfall) begin
                        bit_cnt_reg <= bit_cnt_next;
                        frame_reg   <= mst_frame_next;
                    end
                    bclk_d_reg  <= cur_bclk;
                    frame_d_reg <= cur_frame;
                end
            end

            // Pin drive: enable only where the device is master
            assign pin_out[g].bclk  = bclk_reg;
            assign pin_out[g].frame = frame_reg;
            assign pin_oe[g].bclk   = cfg[g].bclk_master;
            assign pin_oe[g].frame  = cfg[g].frame_master;

            assign clk_level[g].bclk  = bclk_d_reg;
            assign clk_level[g].frame = frame_d_reg;
            assign clk_evt[g].bclk_rise  = cur_bclk & ~bclk_d_reg;
            assign clk_evt[g].bclk_fall  = ~cur_bclk & bclk_d_reg;
            assign clk_evt[g].frame_rise = cur_frame & ~frame_d_reg;
            assign clk_evt[g].frame_fall = ~cur_frame & frame_d_reg;
        end
    endgenerate
endmodule

// ### acl_map.svh
// Constants for the audio interface clock control block
`ifndef ACL_MAP_SVH
`define ACL_MAP_SVH
`define ACL_NUM_IF        3
`define ACL_DIV_W         8
`define ACL_DIV_RST       8'h04
`define ACL_FRAME_RST     8'h40
`define ACL_FW_BASE       20'h80000
`endif

// ### acl_pkg.sv
// Types for the audio interface clock control block
package acl_pkg;
    typedef struct packed {
        logic bclk_master;
        logic frame_master;
        logic use_async;
        logic [7:0] bclk_half;
        logic [7:0] frame_bits;
    } acl_cfg_s;

    typedef struct packed {
        logic bclk;
        logic frame;
    } acl_clk_s;

    typedef struct packed {
        logic bclk_rise;
        logic bclk_fall;
        logic frame_rise;
        logic frame_fall;
    } acl_evt_s;
endpackage

// ### acl_edge_sync.sv
// Two-flop synchroniser with edge detection for one pin
`timescale 1ns/10ps
module acl_edge_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Pin in, level and edges out
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    assign level = s2_reg;
    assign rise  = s2_reg & ~s3_reg;
    assign fall  = ~s2_reg & s3_reg;
endmodule

// ### acl_audio_clk_checker.sv
// Port assertions for the audio clock block
`timescale 1ns/10ps
module acl_audio_clk_checker #(parameter int NUM_IF = 3) (
    // Clock, reset, ticks
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic sys_tick,
    input wire logic async_tick,
    // Mode and pins
    input wire acl_pkg::acl_cfg_s cfg [NUM_IF],
    input wire acl_pkg::acl_clk_s pin_in [NUM_IF],
    input wire acl_pkg::acl_clk_s pin_out [NUM_IF],
    input wire acl_pkg::acl_clk_s pin_oe [NUM_IF],
    input wire acl_pkg::acl_evt_s clk_evt [NUM_IF],
    // Control access
    input wire logic [19:0] spi_addr,
    input wire logic spi_to_fw,
    input wire logic ctrl_ready
);
    import acl_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire logic tick0 = cfg[0].use_async ? async_tick : sys_tick;
    sequence slave_rise;
        !cfg[2].bclk_master && $rose(pin_in[2].bclk);
    endsequence
    a_master_tick: assert property (cfg[0].bclk_master && $changed(pin_out[0].bclk) |-> $past(tick0))
        else $error("bit clock moved without tick");
    a_mixed_oe: assert property (pin_oe[1] == {cfg[1].bclk_master, cfg[1].frame_master})
        else $error("enables do not follow mode");
    // The pin edge reaches clk_evt on the second edge after the one that first sees it
    sequence slave_held;
        slave_rise ##1 !cfg[2].bclk_master;
    endsequence
    a_slave_sync: assert property (slave_held |-> ##1 clk_evt[2].bclk_rise)
        else $error("slave edge not seen");
    a_frame_on_fall: assert property (cfg[0].bclk_master && cfg[0].frame_master && $changed(pin_out[0].frame) |-> $fell(pin_out[0].bclk))
        else $error("frame moved off a bit clock fall");
    a_fw_region: assert property (spi_to_fw == (spi_addr >= 20'h80000))
        else $error("region decode wrong");
    a_ready_held: assert property (ctrl_ready)
        else $error("control access blocked");
endmodule
bind acl_audio_clk acl_audio_clk_checker #(.NUM_IF(NUM_IF)) u_chk (.*);

// ### acl_far_end.sv
// Far-end model driving slave bit and frame clocks
`timescale 1ns/10ps
module acl_far_end (
    // Run control
    input wire logic run,
    // Pins toward the device
    output acl_pkg::acl_clk_s pins
);
    import acl_pkg::*;
    int falls = 0;
    initial begin
        pins = '0;
        #13;
        forever begin
            #160;
            if (run || pins.bclk) begin
                pins.bclk = ~pins.bclk;
                if (!pins.bclk) falls++;
                if (!pins.bclk && falls % 4 == 0) pins.frame = ~pins.frame;
            end
        end
    end
endmodule

// ### acl_audio_clk_tb_top.sv
// Self-checking bench for the audio clock block
`timescale 1ns/10ps
module acl_audio_clk_tb_top;
    import acl_pkg::*;
    logic clk_sys = 0, sys_rst = 1, sys_tick = 0, async_tick = 0, run = 0, spi_to_fw, ctrl_ready;
    logic [19:0] spi_addr = '0;
    acl_cfg_s cfg [3] = '{default: '0};
    acl_clk_s tb_pin = '0, far_pin, pin_in [3], pin_out [3], pin_oe [3], clk_level [3];
    acl_evt_s clk_evt [3];
    int error_cnt = 0, cmp_count = 0, cyc = 0, far_r = 0, evt_r = 0, n, h, fall_n = 0, fr_len = 0;
    logic bclk_q = 0, fr_q = 0;
    assign pin_in = '{tb_pin, tb_pin, far_pin};
    acl_audio_clk dut (.*);
    acl_far_end far (.run(run), .pins(far_pin));
    initial forever #20 clk_sys = ~clk_sys;
    always @(posedge far_pin.bclk) far_r++;
    always @(posedge clk_sys) begin
        async_tick <= 1'($urandom_range(1));
        tb_pin <= 2'($urandom);
        if (clk_evt[2].bclk_rise === 1'b1) evt_r++;
        // Bit clock falls per frame half on interface 0
        if (bclk_q === 1'b1 && pin_out[0].bclk === 1'b0) fall_n++;
        if (pin_out[0].frame !== fr_q) begin
            fr_len = fall_n;
            fall_n = 0;
        end
        bclk_q = pin_out[0].bclk;
        fr_q = pin_out[0].frame;
        if (++cyc == 5000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic chk(input logic [19:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic meas(output int c);
        logic b;
        b = pin_out[0].bclk;
        c = 0;
        do begin
            @(posedge clk_sys);
            #1 c++;
        end while (pin_out[0].bclk === b && c < 50);
    endtask
    task automatic close_out();
        if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        void'($urandom(54627));
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            // One control interface at a time, both regions visited
            spi_addr <= (i < 2) ? 20'h7ffff + 20'(i) : 20'($urandom);
            #1 chk(20'(spi_to_fw), 20'(spi_addr >= 20'h80000));
            chk(20'(ctrl_ready), 20'h1);
        end
        for (int k = 0; k < 4; k++) begin
            h = (k == 0) ? 0 : $urandom_range(3);
            @(posedge clk_sys);
            cfg[0] <= '{1'b1, 1'b1, 1'b0, 8'(h), 8'h02};
            cfg[1] <= '{1'b1, 1'b0, 1'b1, 8'h00, 8'h02};
            sys_tick <= 1'b1;
            meas(n);
            meas(n);
            chk(20'(n), 20'(h + 1));
            chk(20'(pin_oe[0]), 20'h3);
            chk(20'(pin_oe[1]), 20'h2);
        end
        run <= 1'b1;
        repeat (400) @(posedge clk_sys);
        run <= 1'b0;
        repeat (20) @(posedge clk_sys);
        chk(20'(evt_r), 20'(far_r));
        chk(20'(clk_level[2]), 20'(far_pin));
        chk(20'(fr_len), 20'h2);
        close_out();
    end
endmodule
